// ---- src/pull_ctrl_pkg.sv ----
// Package with register map, field positions and pad control types.
package pull_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [15:0] P3_PULL_SELECT_ADDR   = 16'hf08c;
    localparam logic [15:0] P3_PULL_PWR_DOWN_ADDR = 16'hf08d;
    localparam logic [15:0] FUNC_PIN_PULL_ADDR    = 16'hf08e;

    localparam logic [7:0] P3_PULL_SELECT_RESET   = 8'hfc;
    localparam logic [7:0] P3_PULL_PWR_DOWN_RESET = 8'h00;
    localparam logic [7:0] FUNC_PIN_PULL_RESET    = 8'h00;
    localparam logic [7:0] P3_SELECT_WRITE_MASK   = 8'hfc;

    // ------------------------------------------------------------------
    // Field positions of the functional pin register, and the first port-3 pin with a pair
    // ------------------------------------------------------------------
    localparam int IRQ_SEL_BIT     = 0;
    localparam int IRQ_OFF_BIT     = 1;
    localparam int READY_SEL_BIT   = 2;
    localparam int READY_OFF_BIT   = 3;
    localparam int DMA_REQ_OFF_BIT = 4;
    localparam int DATA_BUS_OFF_BIT = 5;
    localparam int VBUS_OFF_BIT    = 6;
    localparam int DATA_LINE7_OFF_BIT = 7;
    localparam int P3_FIRST_PAIR_PIN = 2;

    // Enable pair for one pad with both resistors.
    typedef struct packed {
        logic pullup_en;
        logic pulldown_en;
    } pad_pull_type;

    // Microcontroller register access.
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_access_type;

endpackage

// ---- src/pad_pull_decode.sv ----
// Resistor enable decode for one pad with select and power-down bits.
`timescale 1ns/100ps
module pad_pull_decode
    import pull_ctrl_pkg::*;
(
    // Control bits
    input  wire logic         select_up_in,
    input  wire logic         power_off_in,
    // Resistor enables
    output pad_pull_type      pull_out
);

    // Power-down overrides the selection; otherwise exactly one is on.
    always_comb begin
        pull_out.pullup_en   = ~power_off_in & select_up_in;
        pull_out.pulldown_en = ~power_off_in & ~select_up_in;
    end

endmodule

// ---- src/pad_pull_resistor_control.sv ----
// Pull resistor register bank for port 3 and functional pins.
`timescale 1ns/100ps
module pad_pull_resistor_control
    import pull_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic           mclk_in,
    input  wire logic           rstn_in,
    // Microcontroller register port
    input  reg_access_type      reg_in,
    output logic [7:0]          rdata_out,
    // Port-3 pads
    output logic [1:0]          p3_pullup_en_out,
    output pad_pull_type [7:2]  p3_pull_out,
    // Functional pads
    output pad_pull_type        irq_pin_pull_out,
    output pad_pull_type        ready_pin_pull_out,
    output logic                dma_req_pulldown_en_out,
    output logic                data_bus_pulldown_en_out,
    output logic                vbus_pulldown_en_out,
    output logic                data_line7_pulldown_en_out
);

    // ------------------------------------------------------------------
    // Overview
    // ------------------------------------------------------------------
    // Three byte registers sit on the microcontroller data bus: the
    // port-3 pull select, the port-3 pull power-down and the functional
    // pin pull configuration. A write strobe with a matching address
    // updates one register at the rising edge that samples it.
    //
    // Every pad control is flopped from the next register value, so a
    // pad follows its write at the same edge and never glitches from
    // decode logic. The price is one extra flop per pad control, which
    // is cheap next to a wrong pull on a floating pin.
    //
    // Reads are registered as well: the data shows one cycle after the
    // read strobe and then stands until the next read. A read and a
    // write to the same address in one cycle return the old contents.
    //
    // Unmapped addresses are ignored on write and read back as zero, so
    // the neighbouring registers of the same bus can live in other
    // blocks without any decode here.
    //
    // There is one clock and no pin input, so nothing here needs a
    // synchroniser; the register strobes come from logic on mclk_in.
    //
    // The block does not police the software order between select and
    // power-down bits. Firmware that clears a power-down bit before it
    // sets the select bit briefly connects the wrong resistor.

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] port3_pull_select_q;
    logic [7:0] port3_pull_power_down_q;
    logic [7:0] function_pin_pull_config_q;
    logic [7:0] port3_pull_select_d;
    logic [7:0] port3_pull_power_down_d;
    logic [7:0] function_pin_pull_config_d;
    logic [7:0] rdata_d;

    // Next register values; the select register low bits stay reserved.
    always_comb begin
        port3_pull_select_d        = port3_pull_select_q;
        port3_pull_power_down_d    = port3_pull_power_down_q;
        function_pin_pull_config_d = function_pin_pull_config_q;
        if (reg_in.wr_en) begin
            case (reg_in.addr)
                P3_PULL_SELECT_ADDR: begin
                    port3_pull_select_d = reg_in.wdata
                                          & P3_SELECT_WRITE_MASK;
                end
                P3_PULL_PWR_DOWN_ADDR: begin
                    port3_pull_power_down_d = reg_in.wdata;
                end
                FUNC_PIN_PULL_ADDR: begin
                    function_pin_pull_config_d = reg_in.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Port-3 select storage; all six pins pick the pull-up after reset.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port3_pull_select_q <= P3_PULL_SELECT_RESET;
        end else begin
            port3_pull_select_q <= port3_pull_select_d;
        end
    end

    // Port-3 power-down storage; no pin is powered down after reset, so each pin has its selected resistor on.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            port3_pull_power_down_q <= P3_PULL_PWR_DOWN_RESET;
        end else begin
            port3_pull_power_down_q <= port3_pull_power_down_d;
        end
    end

    // Functional pin storage; reset puts interrupt and ready on pull-down.
    // A cleared register also leaves every single pull-down connected,
    // which keeps the data bus quiet until the bridge drives it.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            function_pin_pull_config_q <= FUNC_PIN_PULL_RESET;
        end else begin
            function_pin_pull_config_q <= function_pin_pull_config_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Read data is registered; unmapped addresses return zero.
    // Without a read strobe the old data is kept, so a slow master may
    // pick it up any number of cycles later. Reserved select bits come
    // back as zero because they are never stored.
    always_comb begin
        rdata_d = rdata_out;
        if (reg_in.rd_en) begin
            case (reg_in.addr)
                P3_PULL_SELECT_ADDR:   rdata_d = port3_pull_select_q;
                P3_PULL_PWR_DOWN_ADDR: rdata_d = port3_pull_power_down_q;
                FUNC_PIN_PULL_ADDR:    rdata_d = function_pin_pull_config_q;
                default:               rdata_d = 8'h00;
            endcase
        end
    end

    // Read data flop; it clears to zero with reset, unlike the pad outputs, which reset to their enabled pulls.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Pad decode
    // ------------------------------------------------------------------
    // Decoded pad enables, taken from next register values.
    pad_pull_type [7:2] p3_pull_d;
    pad_pull_type       irq_pull_d;
    pad_pull_type       ready_pull_d;

    // Port-3 pins 2..7 each have a select and a power-down bit.
    // Pins 0 and 1 have a pull-up only and are handled at the outputs.
    for (genvar pin = P3_FIRST_PAIR_PIN; pin < 8; pin++) begin : g_p3
        pad_pull_decode u_dec (
            .select_up_in (port3_pull_select_d[pin]),
            .power_off_in (port3_pull_power_down_d[pin]),
            .pull_out     (p3_pull_d[pin])
        );
    end

    // Interrupt and ready pins use the same select and power-down pair.
    pad_pull_decode u_irq_dec (
        .select_up_in (function_pin_pull_config_d[IRQ_SEL_BIT]),
        .power_off_in (function_pin_pull_config_d[IRQ_OFF_BIT]),
        .pull_out     (irq_pull_d)
    );

    pad_pull_decode u_ready_dec (
        .select_up_in (function_pin_pull_config_d[READY_SEL_BIT]),
        .power_off_in (function_pin_pull_config_d[READY_OFF_BIT]),
        .pull_out     (ready_pull_d)
    );

    // Pad outputs are flopped from next-state so they track the register
    // in the same cycle; this keeps the outputs glitch free at the pads.
    // Each group has its own flop process, so a change to one group's
    // reset or decode cannot disturb the others.

    // Port-3 pads: pins 0 and 1 carry a pull-up only, the rest a pair.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            p3_pullup_en_out <= 2'h3;
            p3_pull_out      <= {6{2'h2}};
        end else begin
            p3_pullup_en_out <= ~port3_pull_power_down_d[1:0];
            p3_pull_out      <= p3_pull_d;
        end
    end

    // Interrupt and ready pads: both sit on their pull-down after reset.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_pin_pull_out   <= 2'h1;
            ready_pin_pull_out <= 2'h1;
        end else begin
            irq_pin_pull_out   <= irq_pull_d;
            ready_pin_pull_out <= ready_pull_d;
        end
    end

    // Single pull-downs: a set bit disconnects the resistor, so each
    // output is the inverse of its bit. Data line 7 has its own bit
    // apart from the rest of the data bus, so it can stay pulled while
    // the other lines are released.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dma_req_pulldown_en_out    <= 1'b1;
            data_bus_pulldown_en_out   <= 1'b1;
            vbus_pulldown_en_out       <= 1'b1;
            data_line7_pulldown_en_out <= 1'b1;
        end else begin
            dma_req_pulldown_en_out <=
                ~function_pin_pull_config_d[DMA_REQ_OFF_BIT];
            data_bus_pulldown_en_out <=
                ~function_pin_pull_config_d[DATA_BUS_OFF_BIT];
            vbus_pulldown_en_out <=
                ~function_pin_pull_config_d[VBUS_OFF_BIT];
            data_line7_pulldown_en_out <=
                ~function_pin_pull_config_d[DATA_LINE7_OFF_BIT];
        end
    end

endmodule

// ---- test/pull_ctrl_chk.sv ----
// Checker of the pad pull register bank decode and timing.
`timescale 1ns/100ps
module pull_ctrl_chk
    import pull_ctrl_pkg::*;
(
    // Clock, reset and register port
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  reg_access_type    reg_in,
    input  wire logic [7:0]   rdata_out,
    // Pad controls
    input  wire logic [1:0]   p3_pullup_en_out,
    input  pad_pull_type [7:2] p3_pull_out,
    input  pad_pull_type      irq_pin_pull_out,
    input  pad_pull_type      ready_pin_pull_out,
    input  wire logic         dma_req_pulldown_en_out,
    input  wire logic         data_bus_pulldown_en_out,
    input  wire logic         vbus_pulldown_en_out,
    input  wire logic         data_line7_pulldown_en_out
);
    // Address decode of the request, shared by the properties below.
    wire logic mf = reg_in.addr == FUNC_PIN_PULL_ADDR;
    wire logic mp = reg_in.addr == P3_PULL_PWR_DOWN_ADDR;
    wire logic ms = reg_in.addr == P3_PULL_SELECT_ADDR;
    wire logic wf = reg_in.wr_en && mf;
    wire logic [7:0] wd = reg_in.wdata;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    a_irq_pad_write: assert property (wf |=> irq_pin_pull_out ==
        {$past(wd[1:0]) == 2'h1, $past(wd[1:0]) == 2'h0})
        else $error("irq pad");
    a_ready_pad_write: assert property (wf |=>
        ready_pin_pull_out ==
        {$past(wd[3:2]) == 2'h1, $past(wd[3:2]) == 2'h0})
        else $error("rdy pad");
    a_single_pd_write: assert property (wf |=>
        {data_line7_pulldown_en_out, vbus_pulldown_en_out,
         data_bus_pulldown_en_out, dma_req_pulldown_en_out} == ~$past(wd[7:4]))
        else $error("single pulldowns");
    a_p3_low_write: assert property (reg_in.wr_en && mp |=>
        p3_pullup_en_out == ~$past(wd[1:0])) else $error("p3 pull-up");
    a_p3_pair_off: assert property (reg_in.wr_en && mp && wd[2] |=>
        p3_pull_out[2] == 2'h0) else $error("p3 pin2 off");
    a_p3_select_up: assert property (reg_in.wr_en && ms && wd[7] |=>
        !p3_pull_out[7].pulldown_en) else $error("p3 pin7 select");
    a_pads_hold: assert property (!reg_in.wr_en |=>
        $stable({p3_pull_out, p3_pullup_en_out, irq_pin_pull_out,
        ready_pin_pull_out, dma_req_pulldown_en_out,
        data_bus_pulldown_en_out, vbus_pulldown_en_out,
        data_line7_pulldown_en_out}))
        else $error("pads moved without write");
    a_read_back: assert property (wf ##1 !reg_in.wr_en ##1
        (reg_in.rd_en && mf && !reg_in.wr_en) |=>
        rdata_out == $past(wd, 3)) else $error("read back");
    a_unmapped_read: assert property (
        reg_in.rd_en && !(mf || mp || ms) |=>
        rdata_out == 8'h00) else $error("unmapped read");
endmodule

bind pad_pull_resistor_control pull_ctrl_chk u_chk (.mclk_in, .rstn_in,
    .reg_in, .rdata_out, .p3_pullup_en_out, .p3_pull_out, .irq_pin_pull_out,
    .ready_pin_pull_out, .dma_req_pulldown_en_out, .data_bus_pulldown_en_out,
    .vbus_pulldown_en_out, .data_line7_pulldown_en_out);

// ---- test/test_pad_pull_resistor_control.sv ----
// Self-checking bench for the pad pull register bank.
`timescale 1ns/100ps
module test_pad_pull_resistor_control;
    import pull_ctrl_pkg::*;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rback;
    } row_type;
    logic           mclk_in = 1'h0;
    logic           rstn_in = 1'h0;
    reg_access_type reg_in = '0;
    wire logic [7:0]  rdata_out;
    wire logic [21:0] pads;
    logic [7:0]     mp, ms, mf, old;
    int             n_mismatch = 0;
    int             total_checks = 0;
    // Writes then reads; software keeps select before power-down.
    row_type rows [12] = '{'{16'hf08e, 8'h01, 8'h01},
        '{16'hf08e, 8'h03, 8'h03},
        '{16'hf08e, 8'h04, 8'h04}, '{16'hf08e, 8'h0c, 8'h0c},
        '{16'hf08e, 8'h50, 8'h50}, '{16'hf08e, 8'ha0, 8'ha0},
        '{16'hf08d, 8'h03, 8'h03}, '{16'hf08c, 8'h03, 8'h00},
        '{16'hf08d, 8'h00, 8'h00}, '{16'hf08c, 8'hab, 8'ha8},
        '{16'hf08d, 8'h84, 8'h84}, '{16'hf090, 8'h55, 8'h00}};
    pad_pull_resistor_control dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .reg_in(reg_in), .rdata_out(rdata_out),
        .p3_pullup_en_out(pads[21:20]), .p3_pull_out(pads[19:8]),
        .irq_pin_pull_out(pads[7:6]), .ready_pin_pull_out(pads[5:4]),
        .dma_req_pulldown_en_out(pads[3]), .data_bus_pulldown_en_out(pads[2]),
        .vbus_pulldown_en_out(pads[1]), .data_line7_pulldown_en_out(pads[0]));
    // Expected pad controls, worked out from the model registers.
    function automatic logic [21:0] exp_pads();
        logic [21:0] e;
        e[21:20] = ~mp[1:0];
        for (int i = 7; i >= 2; i--)
            e[2*i+4 +: 2] = {ms[i], !ms[i]} & {2{!mp[i]}};
        e[7:6] = {mf[0], !mf[0]} & {2{!mf[1]}};
        e[5:4] = {mf[2], !mf[2]} & {2{!mf[3]}};
        e[3:0] = {!mf[4], !mf[5], !mf[6], !mf[7]};
        return e;
    endfunction
    // One register cycle; the strobe drops at the answering edge.
    task automatic cyc(input logic w, r, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge mclk_in);
        reg_in <= '{w, r, a, d};
        @(posedge mclk_in);
        reg_in <= '0;
        mf = (w && a == FUNC_PIN_PULL_ADDR) ? d : mf;
        mp = (w && a == P3_PULL_PWR_DOWN_ADDR) ? d : mp;
        ms = (w && a == P3_PULL_SELECT_ADDR) ? d & P3_SELECT_WRITE_MASK : ms;
        #1;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk22(input string n, input logic [21:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reset for n cycles, then pads and the select register read back.
    task automatic rst_chk(input int n);
        rstn_in <= 1'h0;
        repeat (n) @(posedge mclk_in);
        rstn_in <= 1'h1;
        {mp, ms, mf} = {8'h00, 8'hfc, 8'h00};
        #1;
        chk22("reset pads", exp_pads(), pads);
        chk8("reset read data", 8'h00, rdata_out);
        cyc(1'h0, 1'h1, P3_PULL_SELECT_ADDR, 8'h00);
        chk8("reset select", 8'hfc, rdata_out);
    endtask
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    // A hang is cut short well past the expected run of some 60 cycles.
    initial begin
        #20000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        rst_chk(5);
        foreach (rows[k]) begin
            cyc(1'h1, 1'h0, rows[k].addr, rows[k].wdata);
            chk22("pads", exp_pads(), pads);
            cyc(1'h0, 1'h1, rows[k].addr, 8'h00);
            chk8("read", rows[k].rback, rdata_out);
        end
        // Write and read in one cycle return the old contents.
        old = mf;
        cyc(1'h1, 1'h1, FUNC_PIN_PULL_ADDR, 8'h3c);
        chk8("same cycle read", old, rdata_out);
        chk22("pads after", exp_pads(), pads);
        rst_chk(2);
        end_of_test();
    end
endmodule
